// >>> pkg/fosr_pkg.sv
package fosr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int SR_W = 8;
    localparam int DQ_W = 16;
    localparam int BANK_W = 3;

    // ****************************************
    // status bit positions
    // ****************************************
    localparam int BIT_READY = 7;
    localparam int BIT_ERS_SUSP = 6;
    localparam int BIT_ERS_ERR = 5;
    localparam int BIT_PRG_ERR = 4;
    localparam int BIT_VPP_ERR = 3;
    localparam int BIT_PRG_SUSP = 2;
    localparam int BIT_LOCK_ERR = 1;
    localparam int BIT_BANK_WORD = 0;

    // ****************************************
    // reset values and upper data byte
    // ****************************************
    localparam logic RST_FLAG = 1'h0;
    localparam logic [BANK_W-1:0] RST_BANK = 3'h0;
    localparam logic [DQ_W-1:0] RST_DQ = 16'h0000;
    localparam logic [DQ_W-SR_W-1:0] DQ_UPPER = 8'h00;
    localparam logic RST_STROBE_N = 1'h1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_SUSP_PEND,
        ST_SUSPENDED
    } fosr_state_t;

    // operation request from the command decoder
    typedef struct packed {
        logic start;
        logic is_erase;
        logic locked;
        logic [BANK_W-1:0] bank;
    } fosr_op_req_t;

    // events from the program/erase sequencer and decoder
    typedef struct packed {
        logic done;
        logic verify_fail;
        logic overwrite_one;
        logic suspend;
        logic paused;
        logic resume;
        logic clear_status;
    } fosr_evt_t;

    // fast multi-word factory program mode
    typedef struct packed {
        logic active;
        logic word_busy;
    } fosr_efp_t;

endpackage

// >>> verilog/fosr_status.sv
`timescale 1ns/1ns
module fosr_status
    import fosr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bus pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic [BANK_W-1:0] addr_bank,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe,
    // programming voltage comparators
    input wire logic vpp_ok,
    input wire logic vpp_high,
    // internal controller side
    input wire fosr_op_req_t op_req,
    input wire fosr_evt_t evt,
    input wire fosr_efp_t fast_multiword_factory_mode,
    input wire logic status_mode,
    output logic op_accept,
    output logic op_abort,
    output logic [SR_W-1:0] status_live
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic ce_n_s1_r, ce_n_s2_r, ce_n_d_r;
    logic oe_n_s1_r, oe_n_s2_r, oe_n_d_r;
    logic vpp_ok_s1_r, vpp_ok_s2_r;
    logic vpp_hi_s1_r, vpp_hi_s2_r;
    logic [BANK_W-1:0] bank_s1_r, bank_s2_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ce_n_s1_r <= RST_STROBE_N;
            ce_n_s2_r <= RST_STROBE_N;
            ce_n_d_r <= RST_STROBE_N;
            oe_n_s1_r <= RST_STROBE_N;
            oe_n_s2_r <= RST_STROBE_N;
            oe_n_d_r <= RST_STROBE_N;
            vpp_ok_s1_r <= RST_FLAG;
            vpp_ok_s2_r <= RST_FLAG;
            vpp_hi_s1_r <= RST_FLAG;
            vpp_hi_s2_r <= RST_FLAG;
            bank_s1_r <= RST_BANK;
            bank_s2_r <= RST_BANK;
        end else begin
            ce_n_s1_r <= ce_n;
            ce_n_s2_r <= ce_n_s1_r;
            ce_n_d_r <= ce_n_s2_r;
            oe_n_s1_r <= oe_n;
            oe_n_s2_r <= oe_n_s1_r;
            oe_n_d_r <= oe_n_s2_r;
            vpp_ok_s1_r <= vpp_ok;
            vpp_ok_s2_r <= vpp_ok_s1_r;
            vpp_hi_s1_r <= vpp_high;
            vpp_hi_s2_r <= vpp_hi_s1_r;
            bank_s1_r <= addr_bank;
            bank_s2_r <= bank_s1_r;
        end
    end

    logic ce_fall, oe_fall, strobe_on;
    assign ce_fall = ce_n_d_r & ~ce_n_s2_r;
    assign oe_fall = oe_n_d_r & ~oe_n_s2_r;
    assign strobe_on = ~ce_n_s2_r & ~oe_n_s2_r;

    // ****************************************
    // controller state
    // ****************************************
    fosr_state_t state_r, state_nxt;
    logic is_erase_r;
    logic [BANK_W-1:0] op_bank_r;
    logic ers_err_r, prg_err_r, vpp_err_r, lock_err_r;
    logic ers_susp_r, prg_susp_r;
    logic any_err, start_ok, start_vpp_bad, start_locked;

    assign any_err = ers_err_r | prg_err_r | vpp_err_r | lock_err_r;
    assign start_ok = op_req.start & ~any_err & vpp_ok_s2_r
                      & ~op_req.locked;
    assign start_vpp_bad = op_req.start & ~vpp_ok_s2_r;
    assign start_locked = op_req.start & op_req.locked;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (evt.done) begin
                    state_nxt = ST_IDLE;
                end else if (evt.suspend) begin
                    state_nxt = ST_SUSP_PEND;
                end
            end
            ST_SUSP_PEND: begin
                if (evt.done) begin
                    state_nxt = ST_IDLE;
                end else if (evt.paused) begin
                    state_nxt = ST_SUSPENDED;
                end
            end
            ST_SUSPENDED: begin
                if (evt.resume) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            is_erase_r <= RST_FLAG;
            op_bank_r <= RST_BANK;
        end else if (state_r == ST_IDLE && start_ok) begin
            is_erase_r <= op_req.is_erase;
            op_bank_r <= op_req.bank;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_accept <= RST_FLAG;
            op_abort <= RST_FLAG;
        end else begin
            op_accept <= (state_r == ST_IDLE) & start_ok;
            op_abort <= (state_r == ST_IDLE) & op_req.start & ~start_ok;
        end
    end

    // ****************************************
    // suspend flags
    // ****************************************
    logic pause_now;
    assign pause_now = (state_r == ST_SUSP_PEND) & evt.paused & ~evt.done;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ers_susp_r <= RST_FLAG;
            prg_susp_r <= RST_FLAG;
        end else if (pause_now) begin
            ers_susp_r <= is_erase_r;
            prg_susp_r <= ~is_erase_r;
        end else if ((state_r == ST_SUSPENDED) && evt.resume) begin
            ers_susp_r <= RST_FLAG;
            prg_susp_r <= RST_FLAG;
        end
    end

    // ****************************************
    // sticky error flags, set wins over clear
    // ****************************************
    logic fin_fail, set_ers, set_prg, set_vpp, set_lock;
    assign fin_fail = evt.done & evt.verify_fail
                      & (state_r == ST_RUN || state_r == ST_SUSP_PEND);
    assign set_ers = fin_fail & is_erase_r;
    assign set_prg = (fin_fail & ~is_erase_r)
                     | (evt.overwrite_one & vpp_hi_s2_r);
    assign set_vpp = (state_r == ST_IDLE) & start_vpp_bad;
    assign set_lock = (state_r == ST_IDLE) & start_locked;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ers_err_r <= RST_FLAG;
            prg_err_r <= RST_FLAG;
            vpp_err_r <= RST_FLAG;
            lock_err_r <= RST_FLAG;
        end else begin
            ers_err_r <= set_ers | (ers_err_r & ~evt.clear_status);
            prg_err_r <= set_prg | (prg_err_r & ~evt.clear_status);
            vpp_err_r <= set_vpp | (vpp_err_r & ~evt.clear_status);
            lock_err_r <= set_lock | (lock_err_r & ~evt.clear_status);
        end
    end

    // ****************************************
    // status value
    // ****************************************
    logic ready, bit0;
    logic [SR_W-1:0] sr_val;
    // ready only when idle or paused
    assign ready = (state_r == ST_IDLE) | (state_r == ST_SUSPENDED);

    always_comb begin
        if (fast_multiword_factory_mode.active) begin
            bit0 = ~ready & fast_multiword_factory_mode.word_busy;
        end else begin
            bit0 = ~ready & (bank_s2_r != op_bank_r);
        end
        sr_val = {ready, ers_susp_r, ers_err_r, prg_err_r,
                  vpp_err_r, prg_susp_r, lock_err_r, bit0};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_live <= {SR_W{RST_FLAG}};
        end else begin
            status_live <= sr_val;
        end
    end

    // ****************************************
    // bus read path
    // ****************************************
    logic sel;
    assign sel = status_mode | (~ready & (bank_s2_r == op_bank_r));

    // capture on fall, hold while low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_o <= RST_DQ;
        end else if ((ce_fall | oe_fall) && sel) begin
            dq_o <= {DQ_UPPER, sr_val};
        end
    end

    // drive only for status reads; array data belongs to another path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_oe <= RST_FLAG;
        end else if (!strobe_on) begin
            dq_oe <= RST_FLAG;
        end else if (ce_fall | oe_fall) begin
            dq_oe <= sel;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_error_sticky: assert property (
        @(posedge clk) disable iff (!arst_n)
        ers_err_r && !evt.clear_status
        |=> ers_err_r)
        else $error("erase error dropped without clear");

    a_clear_errs: assert property (
        @(posedge clk) disable iff (!arst_n)
        evt.clear_status && !evt.overwrite_one && !op_req.start
        && !evt.done |=> ##1 !status_live[BIT_PRG_ERR]
        && !status_live[BIT_VPP_ERR] && !status_live[BIT_LOCK_ERR])
        else $error("error flags not cleared");

    a_ready_busy: assert property (
        @(posedge clk) disable iff (!arst_n)
        op_accept |=> !status_live[BIT_READY])
        else $error("ready high after accepted operation");

    a_susp_wait: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == ST_RUN && evt.suspend && !evt.done
        |=> !ready throughout (##[0:2] 1'b1))
        else $error("ready rose before pause");

    a_susp_flag: assert property (
        @(posedge clk) disable iff (!arst_n)
        pause_now && is_erase_r |=> ers_susp_r && ready
        && !prg_susp_r)
        else $error("erase suspend not flagged on pause");

    a_resume_clr: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == ST_SUSPENDED && evt.resume
        |=> !ers_susp_r && !prg_susp_r && !ready)
        else $error("resume left suspend flag set");

    a_err_blocks: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == ST_IDLE && op_req.start && any_err
        |=> op_abort && !op_accept && state_r == ST_IDLE)
        else $error("command ran with pending error");

    a_vpp_abort: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == ST_IDLE && op_req.start && !vpp_ok_s2_r
        |=> vpp_err_r ##1 status_live[BIT_VPP_ERR])
        else $error("low voltage not flagged");

    a_overwrite: assert property (
        @(posedge clk) disable iff (!arst_n)
        !prg_err_r && !fin_fail && evt.overwrite_one && !vpp_hi_s2_r
        |=> !prg_err_r)
        else $error("overwrite reported without high voltage");

    a_bank_bit: assert property (
        @(posedge clk) disable iff (!arst_n)
        !ready && !fast_multiword_factory_mode.active && bank_s2_r == op_bank_r
        |=> !status_live[BIT_BANK_WORD])
        else $error("bank bit high for busy addressed bank");

    a_upper_low: assert property (
        @(posedge clk) disable iff (!arst_n)
        dq_oe |-> dq_o[DQ_W-1:SR_W] == DQ_UPPER)
        else $error("upper data lines not low");

    a_hold_read: assert property (
        @(posedge clk) disable iff (!arst_n)
        dq_oe && strobe_on && !ce_fall && !oe_fall
        |=> $stable(dq_o))
        else $error("status changed during read");

endmodule

// >>> test/fosr_host.sv
`timescale 1ns/1ns
module fosr_host
    import fosr_pkg::*;
(
    // clock
    input wire logic clk,
    // bus pins
    output logic ce_n,
    output logic oe_n,
    output logic [BANK_W-1:0] addr_bank,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic dq_oe
);
    // ****************************************
    // single word reads
    // ****************************************
    initial begin
        ce_n = 1'h1;
        oe_n = 1'h1;
        addr_bank = 3'h0;
    end

    task automatic open_read(input logic [BANK_W-1:0] bank,
                             output logic [DQ_W-1:0] data,
                             output logic oe);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        addr_bank = bank;
        ce_n = 1'h0;
        oe_n = 1'h0;
        while (dq_oe !== 1'h1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        oe = dq_oe;
        data = dq_o;
    endtask

    task automatic close_read();
        int n;
        n = 0;
        @(posedge clk);
        #1;
        ce_n = 1'h1;
        oe_n = 1'h1;
        // a deselected address does not keep its last value
        addr_bank = ~addr_bank;
        // stay high long enough for the synchronised strobe to rise
        while ((dq_oe !== 1'h0 || n < 3) && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
endmodule

// >>> test/flash_operation_status_register_tb.sv
`timescale 1ns/1ns
module flash_operation_status_register_tb;
    import fosr_pkg::*;
    logic clk, arst_n, ce_n, oe_n, dq_oe, vpp_ok, vpp_high, status_mode;
    logic op_accept, op_abort, ro;
    logic [BANK_W-1:0] addr_bank;
    logic [DQ_W-1:0] dq_o, rd_d;
    logic [SR_W-1:0] status_live;
    fosr_op_req_t op_req;
    fosr_evt_t evt;
    fosr_efp_t fast_multiword_factory_mode;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    fosr_status fosr_status_i (.clk(clk), .arst_n(arst_n), .ce_n(ce_n),
        .oe_n(oe_n), .addr_bank(addr_bank), .dq_o(dq_o), .dq_oe(dq_oe),
        .vpp_ok(vpp_ok), .vpp_high(vpp_high), .op_req(op_req), .evt(evt),
        .fast_multiword_factory_mode(fast_multiword_factory_mode), .status_mode(status_mode), .op_accept(op_accept),
        .op_abort(op_abort), .status_live(status_live));
    fosr_host fosr_host_i (.clk(clk), .ce_n(ce_n), .oe_n(oe_n),
        .addr_bank(addr_bank), .dq_o(dq_o), .dq_oe(dq_oe));

    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial clk = 1'h0;
    always #2 clk = ~clk;

    task automatic print_verdict();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [DQ_W-1:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // mask drops bit 0 where the bank view is not under test
    task automatic ev(input logic [6:0] e, input logic [7:0] exp, mask);
        evt = e;
        tick(1);
        evt = 7'h00;
        tick(1);
        check({8'h00, status_live & mask}, {8'h00, exp & mask});
    endtask

    task automatic st(input logic er, lk, input logic [2:0] bk,
                      input logic [1:0] resp, input logic [7:0] exp, mask);
        logic [1:0] seen;
        op_req = {1'h1, er, lk, bk};
        tick(1);
        op_req = 6'h00;
        seen = {op_accept, op_abort};
        tick(1);
        seen = seen | {op_accept, op_abort};
        tick(1);
        check({14'h0000, seen}, {14'h0000, resp});
        check({8'h00, status_live & mask}, {8'h00, exp & mask});
    endtask

    task automatic rd(input logic [2:0] bk, input logic oe,
                      input logic [DQ_W-1:0] exp);
        fosr_host_i.open_read(bk, rd_d, ro);
        check({15'h0000, ro}, {15'h0000, oe});
        if (oe) check(rd_d, exp);
        fosr_host_i.close_read();
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        arst_n = 1'h0;
        vpp_ok = 1'h1;
        vpp_high = 1'h0;
        status_mode = 1'h1;
        op_req = 6'h00;
        evt = 7'h00;
        fast_multiword_factory_mode = 2'h0;
        tick(20);
        arst_n = 1'h1;
        tick(4);
        check({8'h00, status_live}, 16'h0080);
        rd(3'h4, 1'h1, 16'h0080);
        // captured value stays while the operation changes state
        fosr_host_i.open_read(3'h3, rd_d, ro);
        st(1'h0, 1'h0, 3'h3, 2'h2, 8'h00, 8'hfe);
        check(dq_o, 16'h0080);
        ev(7'h40, 8'h80, 8'hff);
        fosr_host_i.close_read();
        st(1'h1, 1'h0, 3'h2, 2'h2, 8'h00, 8'hfe);
        status_mode = 1'h0;
        rd(3'h2, 1'h1, 16'h0000);
        rd(3'h5, 1'h0, 16'h0000);
        status_mode = 1'h1;
        rd(3'h5, 1'h1, 16'h0001);
        rd(3'h2, 1'h1, 16'h0000);
        ev(7'h08, 8'h00, 8'hfe);
        ev(7'h04, 8'hc0, 8'hfe);
        ev(7'h02, 8'h00, 8'hfe);
        ev(7'h60, 8'ha0, 8'hff);
        st(1'h0, 1'h0, 3'h1, 2'h1, 8'ha0, 8'hff);
        ev(7'h01, 8'h80, 8'hff);
        st(1'h0, 1'h0, 3'h1, 2'h2, 8'h00, 8'hfe);
        ev(7'h08, 8'h00, 8'hfe);
        ev(7'h40, 8'h80, 8'hff);
        st(1'h0, 1'h0, 3'h1, 2'h2, 8'h00, 8'hfe);
        ev(7'h08, 8'h00, 8'hfe);
        ev(7'h04, 8'h84, 8'hfe);
        ev(7'h02, 8'h00, 8'hfe);
        ev(7'h60, 8'h90, 8'hff);
        ev(7'h01, 8'h80, 8'hff);
        ev(7'h10, 8'h80, 8'hff);
        vpp_high = 1'h1;
        tick(4);
        ev(7'h10, 8'h90, 8'hff);
        ev(7'h01, 8'h80, 8'hff);
        vpp_high = 1'h0;
        vpp_ok = 1'h0;
        tick(4);
        st(1'h0, 1'h0, 3'h0, 2'h1, 8'h88, 8'hff);
        ev(7'h01, 8'h80, 8'hff);
        st(1'h1, 1'h1, 3'h0, 2'h1, 8'h8a, 8'hff);
        ev(7'h01, 8'h80, 8'hff);
        vpp_ok = 1'h1;
        tick(4);
        st(1'h0, 1'h1, 3'h6, 2'h1, 8'h82, 8'hff);
        // a hardware reset while idle also clears the sticky flags
        arst_n = 1'h0;
        tick(2);
        arst_n = 1'h1;
        tick(4);
        check({8'h00, status_live}, 16'h0080);
        ev(7'h01, 8'h80, 8'hff);
        fast_multiword_factory_mode = 2'h3;
        st(1'h0, 1'h0, 3'h0, 2'h2, 8'h01, 8'hff);
        fast_multiword_factory_mode = 2'h2;
        tick(2);
        check({8'h00, status_live}, 16'h0000);
        ev(7'h40, 8'h80, 8'hff);
        fast_multiword_factory_mode = 2'h0;
        tick(2);
        print_verdict();
    end
endmodule
